// ### hdl/crc_byte_step.sv
`timescale 1ns/100ps
`default_nettype none

module crc_byte_step
	import crc_pkg::*;
(
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data_in,
	input wire logic wide,
	output logic [31:0] crc_out
);

	// --------------------------------------------------------------
	// one whole byte per call
	// --------------------------------------------------------------
	// wide mode feeds data lsb first into an msb-first register,
	// so the reflected result is obtained by reversing on read
	always_comb begin
		logic [31:0] c;
		logic fb;
		c = crc_in;
		fb = 1'b0;
		for (int i = 0; i < BYTE_BITS; i++) begin
			if (wide) begin
				fb = c[WIDE_MSB] ^ data_in[i];
				c = {c[WIDE_MSB-1:0], 1'b0} ^ (fb ? POLY_WIDE : CRC_ZEROS);
			end else begin
				fb = c[NARROW_MSB] ^ data_in[BYTE_BITS-1-i];
				c = {16'h0000, c[NARROW_MSB-1:0], 1'b0} ^ (fb ? POLY_NARROW : CRC_ZEROS);
			end
		end
		crc_out = c;
	end

endmodule : crc_byte_step

`default_nettype wire

// ### hdl/crc_checksum_generator.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module crc_checksum_generator
	import crc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] dma_valid,
	input wire logic [3:0][7:0] dma_data,
	input wire logic [3:0] dma_done,
	input wire logic flash_valid,
	input wire logic [7:0] flash_data,
	input wire logic flash_done,
	output logic crc_busy
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	phase_t phase;
	phase_t next_phase;
	logic [1:0] reset_code;
	logic [3:0] source;
	logic wide_poly_select;
	logic zero_flag;
	logic [31:0] crc_value;
	logic [7:0] byte_input;

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	logic wr_ctrl;
	logic wr_status;
	logic wr_byte;
	logic wr_result;
	logic reset_req;
	logic busy;
	logic eff_wide;
	logic dma_sel;
	logic [1:0] chan;
	logic [3:0] new_source;

	assign wr_ctrl = reg_write && (reg_addr == ADDR_CONTROL);
	assign wr_status = reg_write && (reg_addr == ADDR_STATUS);
	assign wr_byte = reg_write && (reg_addr == ADDR_BYTE_INPUT);
	assign wr_result = reg_write && (reg_addr >= ADDR_RESULT0);
	assign reset_req = wr_ctrl && reg_wdata[CTRL_RESET_HI];
	assign busy = (phase == PH_RUN);
	assign eff_wide = wide_poly_select || (source == SRC_FLASH);
	assign dma_sel = (source >= dma_chan_zero_source) && (source <= dma_chan_three_source);
	assign chan = source[1:0];

	// reserved codes fall back to disabled
	always_comb begin
		new_source = reg_wdata[CTRL_SRC_HI:0];
		if (!(new_source <= SRC_FLASH || (new_source >= dma_chan_zero_source
				&& new_source <= dma_chan_three_source))) begin
			new_source = SRC_DISABLED;
		end
	end

	// --------------------------------------------------------------
	// byte feed
	// --------------------------------------------------------------
	logic cpu_take;
	logic dma_take;
	logic flash_take;
	logic feed;
	logic [7:0] feed_data;
	logic [31:0] step_crc;
	logic [31:0] next_crc;
	logic done;
	logic finish_zero;

	assign cpu_take = busy && wr_byte && (source == SRC_CPU);
	assign dma_take = busy && dma_sel && dma_valid[chan];
	assign flash_take = busy && (source == SRC_FLASH) && flash_valid;
	assign feed = cpu_take || dma_take || flash_take;

	always_comb begin
		feed_data = BYTE_ZERO;
		if (cpu_take) begin
			feed_data = reg_wdata;
		end else if (dma_take) begin
			feed_data = dma_data[chan];
		end else if (flash_take) begin
			feed_data = flash_data;
		end
	end

	crc_byte_step u_step (
		.crc_in(crc_value),
		.data_in(feed_data),
		.wide(eff_wide),
		.crc_out(step_crc)
	);

	assign next_crc = feed ? step_crc : crc_value;

	// --------------------------------------------------------------
	// completion
	// --------------------------------------------------------------
	assign done = busy && (
		((source == SRC_CPU) && wr_status && reg_wdata[STATUS_BUSY_BIT]) ||
		(dma_sel && dma_done[chan]) ||
		((source == SRC_FLASH) && flash_done));

	function automatic logic [31:0] result_view(input logic [31:0] v, input logic w);
		logic [31:0] r;
		r = {<<{v}};
		return w ? ~r : v;
	endfunction : result_view

	// narrow mode only compares the low half
	assign finish_zero = ((result_view(next_crc, eff_wide)
		& (eff_wide ? CRC_ONES : NARROW_MASK)) == CRC_ZEROS);

	// --------------------------------------------------------------
	// phase machine
	// --------------------------------------------------------------
	always_comb begin
		next_phase = phase;
		unique case (phase)
			PH_IDLE: begin
				if (reset_req) begin
					next_phase = PH_RESET;
				end else if (wr_ctrl && new_source != SRC_DISABLED) begin
					next_phase = PH_RUN;
				end
			end
			PH_RUN: begin
				if (reset_req) begin
					next_phase = PH_RESET;
				end else if (done) begin
					next_phase = PH_IDLE;
				end
			end
			PH_RESET: begin
				next_phase = reset_req ? PH_RESET : PH_IDLE;
			end
			default: begin
				next_phase = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			phase <= PH_IDLE;
			crc_busy <= 1'b0;
		end else begin
			phase <= next_phase;
			crc_busy <= (next_phase == PH_RUN);
		end
	end

	// reset code waits one cycle before acting
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reset_code <= 2'h0;
		end else if (reset_req) begin
			reset_code <= reg_wdata[CTRL_RESET_HI:CTRL_RESET_LO];
		end
	end

	// --------------------------------------------------------------
	// control fields and zero flag
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			source <= SRC_DISABLED;
			wide_poly_select <= 1'b0;
		end else if (phase == PH_RESET) begin
			source <= SRC_DISABLED;
			wide_poly_select <= 1'b0;
		end else if (phase == PH_IDLE && wr_ctrl && !reset_req) begin
			source <= new_source;
			wide_poly_select <= reg_wdata[CTRL_WIDE_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			zero_flag <= 1'b0;
		end else if (phase == PH_RESET) begin
			zero_flag <= 1'b0;
		end else if (done) begin
			zero_flag <= finish_zero;
		end else if (phase == PH_IDLE && wr_ctrl && !reset_req) begin
			zero_flag <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// checksum and byte input
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			crc_value <= CRC_ZEROS;
		end else if (phase == PH_RESET) begin
			crc_value <= (reset_code == RESET_ONES) ? CRC_ONES : CRC_ZEROS;
		end else if (wr_result && source == SRC_DISABLED) begin
			crc_value[reg_addr[1:0]*BYTE_BITS +: BYTE_BITS] <= reg_wdata;
		end else begin
			crc_value <= next_crc;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			byte_input <= BYTE_ZERO;
		end else if (cpu_take) begin
			byte_input <= reg_wdata;
		end
	end

	// --------------------------------------------------------------
	// read port
	// --------------------------------------------------------------
	logic [31:0] view;
	logic [7:0] rd_mux;

	always_comb begin
		view = result_view(crc_value, eff_wide && !busy);
		if (source == SRC_FLASH && busy) begin
			view = CRC_ZEROS;
		end
		rd_mux = BYTE_ZERO;
		unique case (reg_addr)
			ADDR_CONTROL: rd_mux = {2'b00, wide_poly_select, 1'b0, source};
			ADDR_STATUS: rd_mux = {6'b00_0000, zero_flag, busy};
			ADDR_BYTE_INPUT: rd_mux = byte_input;
			ADDR_RESULT0: rd_mux = view[7:0];
			ADDR_RESULT1: rd_mux = view[15:8];
			ADDR_RESULT2: rd_mux = view[23:16];
			ADDR_RESULT3: rd_mux = view[31:24];
			default: rd_mux = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= BYTE_ZERO;
		end else begin
			reg_rdata <= reg_read ? rd_mux : BYTE_ZERO;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	sequence clear_request;
		wr_ctrl && reg_wdata[CTRL_RESET_HI:CTRL_RESET_LO] == RESET_ZEROS;
	endsequence

	sequence preset_request;
		wr_ctrl && reg_wdata[CTRL_RESET_HI:CTRL_RESET_LO] == RESET_ONES;
	endsequence

	sequence pending_then_idle;
		##1 (phase == PH_RESET && !reset_req) ##1 (phase == PH_IDLE);
	endsequence

	sw_clear_zero_a: assert property (
		clear_request |-> pending_then_idle ##0 (crc_value == CRC_ZEROS && source == SRC_DISABLED))
		else $error("clear code did not zero checksum");

	sw_preset_ones_a: assert property (
		preset_request ##1 !reset_req |-> ##1 (crc_value == CRC_ONES && !busy))
		else $error("preset code did not set ones");

	mode_lock_a: assert property (
		busy && wr_ctrl && !reset_req |=> $stable(wide_poly_select) && $stable(source))
		else $error("mode or source changed while busy");

	busy_source_a: assert property (
		busy |-> source != SRC_DISABLED && crc_busy == 1'b1)
		else $error("busy without a source");

	cpu_done_a: assert property (
		busy && source == SRC_CPU && wr_status && reg_wdata[STATUS_BUSY_BIT] && !reset_req
		|=> !busy && !crc_busy)
		else $error("cpu completion did not clear busy");

	dma_done_a: assert property (
		busy && dma_sel && dma_done[chan] && !reset_req |=> !busy && !crc_busy)
		else $error("dma completion did not clear busy");

	flash_done_a: assert property (
		busy && source == SRC_FLASH && flash_done && !reset_req |=> phase == PH_IDLE)
		else $error("flash completion did not clear busy");

	byte_fold_a: assert property (
		cpu_take && !reset_req |=> crc_value == $past(step_crc))
		else $error("byte input not folded in one cycle");

	zero_clear_a: assert property (
		phase == PH_IDLE && wr_ctrl && !reset_req |=> !zero_flag)
		else $error("zero flag survived new source");

	flash_read_zero_a: assert property (
		reg_read && reg_addr >= ADDR_RESULT0 && busy && source == SRC_FLASH
		|=> reg_rdata == BYTE_ZERO)
		else $error("flash checksum visible while busy");

	result_lock_a: assert property (
		wr_result && source != SRC_DISABLED && !feed && phase != PH_RESET
		|=> $stable(crc_value))
		else $error("checksum written while source selected");

	dma_fold_a: assert property (
		dma_take && !reset_req |=> crc_value == $past(step_crc))
		else $error("dma byte not folded in one cycle");

	other_channel_a: assert property (
		busy && dma_sel && !dma_valid[chan] && !reset_req |=> $stable(crc_value))
		else $error("checksum moved without a byte from the chosen channel");

	reserved_source_a: assert property (
		phase == PH_IDLE && wr_ctrl && !reset_req
		&& (reg_wdata[CTRL_SRC_HI] || reg_wdata[CTRL_SRC_HI:0] == (SRC_CPU | SRC_FLASH))
		|=> source == SRC_DISABLED && !busy)
		else $error("reserved source code was kept");

	rdata_idle_a: assert property (
		!reg_read |=> reg_rdata == BYTE_ZERO)
		else $error("read data shown outside its cycle");

	control_readback_a: assert property (
		reg_read && reg_addr == ADDR_CONTROL |=> reg_rdata[CTRL_RESET_HI:CTRL_RESET_LO] == '0)
		else $error("reset field read back nonzero");

endmodule : crc_checksum_generator

`default_nettype wire

// ### hdl/crc_pkg.sv
package crc_pkg;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_BYTE_INPUT = 3'h3;
	localparam logic [2:0] ADDR_RESULT0 = 3'h4;
	localparam logic [2:0] ADDR_RESULT1 = 3'h5;
	localparam logic [2:0] ADDR_RESULT2 = 3'h6;
	localparam logic [2:0] ADDR_RESULT3 = 3'h7;

	// --------------------------------------------------------------
	// field layout
	// --------------------------------------------------------------
	localparam int CTRL_RESET_HI = 7;
	localparam int CTRL_RESET_LO = 6;
	localparam int CTRL_WIDE_BIT = 5;
	localparam int CTRL_SRC_HI = 3;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int BYTE_BITS = 8;
	localparam int NARROW_MSB = 15;
	localparam int WIDE_MSB = 31;
	localparam int DMA_CHANNELS = 4;

	localparam logic [1:0] RESET_ZEROS = 2'h2;
	localparam logic [1:0] RESET_ONES = 2'h3;

	localparam logic [3:0] SRC_DISABLED = 4'h0;
	localparam logic [3:0] SRC_CPU = 4'h1;
	localparam logic [3:0] SRC_FLASH = 4'h2;
	localparam logic [3:0] dma_chan_zero_source = 4'h4;
	localparam logic [3:0] dma_chan_three_source = 4'h7;

	// --------------------------------------------------------------
	// polynomials and reset values
	// --------------------------------------------------------------
	localparam logic [31:0] POLY_NARROW = 32'h0000_1021;
	localparam logic [31:0] POLY_WIDE = 32'h04c1_1db7;
	localparam logic [31:0] NARROW_MASK = 32'h0000_ffff;
	localparam logic [31:0] CRC_ZEROS = 32'h0000_0000;
	localparam logic [31:0] CRC_ONES = 32'hffff_ffff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_RUN = 3'b010,
		PH_RESET = 3'b100
	} phase_t;

endpackage : crc_pkg

// ### testbench/crc_source_model.sv
`timescale 1ns/100ps
`default_nettype none

module crc_source_model (
	input wire logic sys_clk,
	output logic [3:0] dma_valid,
	output logic [3:0][7:0] dma_data,
	output logic [3:0] dma_done,
	output logic flash_valid,
	output logic [7:0] flash_data,
	output logic flash_done
);
	initial begin
		dma_valid = 4'h0;
		dma_data = 32'h0000_0000;
		dma_done = 4'h0;
		flash_valid = 1'b0;
		flash_data = 8'h00;
		flash_done = 1'b0;
	end

	// port 4 is the flash controller; released data lines show the inverse
	task automatic stream(input int port, input logic [7:0] first, input int count,
			input int gap, input bit fin);
		logic [7:0] b;
		b = first;
		for (int i = 0; i < count; i++) begin
			@(posedge sys_clk);
			if (port == 4) begin
				flash_valid <= 1'b1;
				flash_data <= b;
			end else begin
				dma_valid[port] <= 1'b1;
				dma_data[port] <= b;
			end
			if (gap > 0) begin
				@(posedge sys_clk);
				flash_valid <= 1'b0;
				dma_valid <= 4'h0;
				flash_data <= ~b;
				dma_data <= ~dma_data;
				repeat (gap - 1) @(posedge sys_clk);
			end
			b = b + 8'h3b;
		end
		@(posedge sys_clk);
		flash_valid <= 1'b0;
		dma_valid <= 4'h0;
		flash_data <= ~flash_data;
		dma_data <= ~dma_data;
		if (port == 4) begin
			flash_done <= fin;
		end else begin
			dma_done[port] <= fin;
		end
		@(posedge sys_clk);
		flash_done <= 1'b0;
		dma_done <= 4'h0;
		#1;
	endtask : stream
endmodule : crc_source_model

`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import crc_pkg::*;

	logic sys_clk;
	logic reset;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_write;
	logic reg_read;
	logic [7:0] reg_rdata;
	logic [3:0] dma_valid;
	logic [3:0][7:0] dma_data;
	logic [3:0] dma_done;
	logic flash_valid;
	logic [7:0] flash_data;
	logic flash_done;
	logic crc_busy;
	int miscompares;
	int n_checks;
	logic [31:0] crc;

	crc_checksum_generator DUT (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .dma_valid(dma_valid), .dma_data(dma_data),
		.dma_done(dma_done), .flash_valid(flash_valid), .flash_data(flash_data),
		.flash_done(flash_done), .crc_busy(crc_busy));

	crc_source_model far_side (.sys_clk(sys_clk), .dma_valid(dma_valid),
		.dma_data(dma_data), .dma_done(dma_done), .flash_valid(flash_valid),
		.flash_data(flash_data), .flash_done(flash_done));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] d,
			input bit wide);
		logic fb;
		for (int i = 0; i < 8; i++) begin
			if (wide) begin
				fb = c[31] ^ d[i];
				c = {c[30:0], 1'b0} ^ (fb ? POLY_WIDE : CRC_ZEROS);
			end else begin
				fb = c[15] ^ d[7 - i];
				c = {16'h0000, c[14:0], 1'b0} ^ (fb ? POLY_NARROW : CRC_ZEROS);
			end
		end
		return c;
	endfunction : step

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : rd

	task automatic rd_result(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++) rd(3'(4 + i), v[8 * i +: 8]);
	endtask : rd_result

	// back-to-back byte writes, then byte 0 read in the very next cycle
	task automatic feed(input logic [7:0] first, input int n, input bit wide);
		logic [7:0] b;
		b = first;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			reg_write <= 1'b1;
			reg_addr <= ADDR_BYTE_INPUT;
			reg_wdata <= b;
			crc = step(crc, b, wide);
			b = b + 8'h3b;
		end
		@(posedge sys_clk);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		reg_addr <= ADDR_RESULT0;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 check(reg_rdata, crc[7:0]);
	endtask : feed

	task automatic clean(input logic [1:0] code);
		wr(ADDR_CONTROL, {code, 6'h00});
		repeat (2) @(posedge sys_clk);
		crc = (code == RESET_ONES) ? CRC_ONES : CRC_ZEROS;
	endtask : clean

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_reset_map;
		logic [3:0][7:0] codes;
		codes = {8'h0f, 8'h0c, 8'h08, 8'h03};
		for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
		check(crc_busy, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CONTROL, codes[k]);
			rd(ADDR_CONTROL, 8'h00);
			check(crc_busy, 1'b0);
		end
		wr(ADDR_BYTE_INPUT, 8'h55);
		rd(ADDR_BYTE_INPUT, 8'h00);
		rd(ADDR_RESULT0, 8'h00);
		wr(ADDR_RESULT0, 8'h5a);
		rd(ADDR_RESULT0, 8'h5a);
		clean(RESET_ONES);
		rd_result(CRC_ONES, 4);
	endtask : t_reset_map

	task automatic t_cpu_narrow;
		clean(RESET_ZEROS);
		rd_result(CRC_ZEROS, 4);
		wr(ADDR_CONTROL, 8'h01);
		check(crc_busy, 1'b1);
		wr(ADDR_CONTROL, 8'h24);
		wr(ADDR_RESULT1, 8'ha5);
		rd(ADDR_CONTROL, 8'h01);
		feed(8'h31, 9, 1'b0);
		rd(ADDR_RESULT1, crc[15:8]);
		wr(ADDR_STATUS, 8'h01);
		check(crc_busy, 1'b0);
		rd(ADDR_STATUS, (crc[15:0] == 16'h0000) ? 8'h02 : 8'h00);
		rd_result(crc, 2);
		wr(ADDR_CONTROL, 8'h40);
		rd_result(crc, 2);
	endtask : t_cpu_narrow

	task automatic t_zero_flag;
		logic [15:0] s;
		clean(RESET_ZEROS);
		wr(ADDR_CONTROL, 8'h01);
		feed(8'h10, 4, 1'b0);
		s = crc[15:0];
		feed(s[15:8], 1, 1'b0);
		feed(s[7:0], 1, 1'b0);
		wr(ADDR_STATUS, 8'h01);
		rd(ADDR_STATUS, 8'h02);
		wr(ADDR_CONTROL, 8'h01);
		rd(ADDR_STATUS, 8'h01);
		wr(ADDR_STATUS, 8'h01);
	endtask : t_zero_flag

	task automatic t_cpu_wide;
		logic [31:0] s;
		clean(RESET_ONES);
		wr(ADDR_CONTROL, 8'h21);
		feed(8'h61, 5, 1'b1);
		rd_result(crc, 4);
		s = ~{<<{crc}};
		for (int i = 0; i < 4; i++) feed(s[8 * i +: 8], 1, 1'b1);
		wr(ADDR_STATUS, 8'h01);
		rd_result(32'h2144_df1c, 4);
	endtask : t_cpu_wide

	task automatic t_dma;
		logic [7:0] b;
		for (int ch = 0; ch < 4; ch++) begin
			clean(RESET_ZEROS);
			wr(ADDR_CONTROL, 8'(4 + ch));
			far_side.stream((ch + 1) % 4, 8'h77, 1, 0, 1'b0);
			check(crc_busy, 1'b1);
			far_side.stream(ch, 8'(8'h20 + ch), 6, ch, 1'b1);
			b = 8'(8'h20 + ch);
			for (int i = 0; i < 6; i++) begin
				crc = step(crc, b, 1'b0);
				b = b + 8'h3b;
			end
			check(crc_busy, 1'b0);
			rd_result(crc, 2);
		end
	endtask : t_dma

	task automatic t_flash;
		logic [7:0] b;
		clean(RESET_ONES);
		wr(ADDR_CONTROL, 8'h02);
		rd_result(CRC_ZEROS, 4);
		far_side.stream(4, 8'h45, 5, 2, 1'b1);
		b = 8'h45;
		for (int i = 0; i < 5; i++) begin
			crc = step(crc, b, 1'b1);
			b = b + 8'h3b;
		end
		check(crc_busy, 1'b0);
		rd_result(~{<<{crc}}, 4);
	endtask : t_flash

	// ----------------------------------------------------------
	// run
	// ----------------------------------------------------------
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		test_done();
	end

	initial begin
		reset = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		miscompares = 0;
		n_checks = 0;
		crc = CRC_ZEROS;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset_map();
		t_cpu_narrow();
		t_zero_flag();
		t_cpu_wide();
		t_dma();
		t_flash();
		test_done();
	end
endmodule : testbench

`default_nettype wire
